/* File: src/slave_port_regs.vh */
/*
 * Register offsets, field positions, reset values and phase timing for the
 * parallel slave port. Definitions only; included by the design file.
 */
`ifndef SLAVE_PORT_REGS_VH
`define SLAVE_PORT_REGS_VH

// Register indices as printed; byte address is four times the index.
`define IDX_DATA_LATCH 8'h08
`define IDX_CTRL_PIN 8'h09
`define IDX_CORE_INT 8'h0B
`define IDX_PERIPH_FLAGS 8'h0C
`define IDX_STATUS_DIR 8'h89
`define IDX_PERIPH_EN 8'h8C
`define IDX_ANALOG_CFG 8'h9F
`define IDX_DATA_DIR 8'h88

// Field positions in the status and direction register.
`define BIT_IBF 7
`define BIT_OBF 6
`define BIT_INPUT_OVERFLOW 5
`define BIT_MODE 4
// Field position of the slave port flag and enable.
`define BIT_SPIF 7

// Reset values.
`define RST_STATUS_DIR 8'h07
`define RST_ZERO8 8'h00
`define RST_ANALOG 3'h0
`define RST_DATA_DIR 8'hFF
`define RST_CTRL_PIN 3'h0

// Instruction cycle phases: counter values for phase one, phase two and phase four.
`define PHASE_ONE 2'h0
`define PHASE_TWO 2'h1
`define PHASE_FOUR 2'h3

`endif

/* File: src/parallel_slave_port.v */
/*
 * Parallel slave port with its APB register file.
 * Assumes an APB master on pclk and an external 8-bit bus master driving
 * active-low strobes and the data pins asynchronously to pclk.
 */
// Decided for this implementation: register access over APB.
// What this block does
// (R1) Mode bit makes data port an async slave
// (R2) Mode bit turns control pins into strobes
// (R3) Firmware sets pins input and digital first; the block does not check this, and the analog setting drives nothing
// (R4) Separate 8-bit output and input latches
// (R5) Write loads output, read returns input latch
// (R6) Data direction register ignored in slave mode
// (R7) Write starts on chip-select and write low
// (R8) Input full set phase four after phase two
// (R9) Irq flag set with input full
// (R10) In slave mode only firmware data read clears input full
// (R11) Second unread write sets overflow flag
// (R12) Read drives output latch onto bus
// (R13) Read start clears output full at once
// (R14) Read end sets irq flag phase-timed
// (R15) Output full stays clear until firmware write
// (R16) Mode off holds both full flags clear
// (R17) Overflow stays set until firmware clears
// (R18) Irq flag latched, forwarded only when enabled
// (R19) Strobes synchronised; data latched during write
// (R20) Active-low strobes; four phases per cycle
`timescale 1ns/1ps
`include "slave_port_regs.vh"

module parallel_slave_port (
   // APB clock and reset.
   input wire pclk,
   input wire presetn,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Control pins: read, write and chip-select strobes, active low.
   input wire rd_n_in,
   input wire wr_n_in,
   input wire cs_n_in,
   output reg [2:0] ctrl_out,
   output reg [2:0] ctrl_oe,
   // Data pins.
   input wire [7:0] data_in,
   output reg [7:0] data_out,
   output reg [7:0] data_oe,
   // Slave port interrupt request to the core.
   output reg irq
);

   // Byte address of a register index.
   function [31:0] reg_addr;
      input [7:0] idx;
      begin
         reg_addr = {22'h0, idx, 2'h0};
      end
   endfunction

   // Registers.
   reg [7:0] out_latch_reg;
   reg [7:0] in_latch_reg;
   reg [7:0] data_dir_reg;
   reg [2:0] ctrl_pin_reg;
   reg [7:0] status_dir_reg;
   reg [7:0] core_int_reg;
   reg [7:0] periph_flags_reg;
   reg [7:0] periph_en_reg;
   reg [2:0] analog_cfg_reg;
   reg [1:0] phase_reg;
   // Data pin delay line, kept in step with the strobe synchronisers.
   reg [7:0] data_s1_reg;
   reg [7:0] data_s2_reg;
   reg [7:0] data_s3_reg;
   reg [7:0] data_s4_reg;

   // Strobe synchronisers: three stages each, change accepted when 2 and 3 agree.
   reg [2:0] rd_s_reg;
   reg [2:0] wr_s_reg;
   reg [2:0] cs_s_reg;
   reg rd_q_reg;
   reg wr_q_reg;
   reg cs_q_reg;
   // Pending completion: waiting for phase two, then phase four.
   reg wr_pend_reg;
   reg wr_seen2_reg;
   reg rd_pend_reg;
   reg rd_seen2_reg;

   wire mode = status_dir_reg[`BIT_MODE];
   wire wr_act = mode & ~cs_q_reg & ~wr_q_reg;
   wire rd_act = mode & ~cs_q_reg & ~rd_q_reg;
   // Raw async read detect for the immediate flag clear and bus drive. Only
   // these uses bypass the synchronisers: settling margin is traded for speed.
   wire rd_raw = mode & ~cs_n_in & ~rd_n_in;
   wire wr_raw = mode & ~cs_n_in & ~wr_n_in;

   wire acc = psel & penable;
   wire wr_acc = acc & pwrite;
   wire rd_acc = acc & ~pwrite;
   wire hit_data = paddr == reg_addr(`IDX_DATA_LATCH);
   wire hit_ctrl = paddr == reg_addr(`IDX_CTRL_PIN);
   wire hit_core = paddr == reg_addr(`IDX_CORE_INT);
   wire hit_flags = paddr == reg_addr(`IDX_PERIPH_FLAGS);
   wire hit_stat = paddr == reg_addr(`IDX_STATUS_DIR);
   wire hit_en = paddr == reg_addr(`IDX_PERIPH_EN);
   wire hit_ana = paddr == reg_addr(`IDX_ANALOG_CFG);
   // The data direction register is reachable in both modes; only general port drive uses it.
   wire hit_dir = paddr == reg_addr(`IDX_DATA_DIR);
   wire hit_any = hit_data | hit_ctrl | hit_core | hit_flags |
                  hit_stat | hit_en | hit_ana | hit_dir;

   wire at_p2 = phase_reg == `PHASE_TWO;
   wire at_p4 = phase_reg == `PHASE_FOUR;
   wire wr_done = wr_pend_reg & wr_seen2_reg & at_p4;
   wire rd_done = rd_pend_reg & rd_seen2_reg & at_p4;

   // Four-phase instruction cycle counter. It runs free from reset, so a
   // completion lands two to five clocks after the release is accepted.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= `PHASE_ONE;
      end else begin
         phase_reg <= phase_reg + 2'h1; // [R20]
      end
   end

   // Strobe synchronisers; the accepted level only moves when stages agree,
   // which also drops a one-clock glitch on a strobe pin.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_s_reg <= 3'h7;
         wr_s_reg <= 3'h7;
         cs_s_reg <= 3'h7;
         rd_q_reg <= 1'b1;
         wr_q_reg <= 1'b1;
         cs_q_reg <= 1'b1;
      end else begin
         rd_s_reg <= {rd_s_reg[1:0], rd_n_in}; // [R19]
         wr_s_reg <= {wr_s_reg[1:0], wr_n_in};
         cs_s_reg <= {cs_s_reg[1:0], cs_n_in};
         if (rd_s_reg[1] == rd_s_reg[2]) begin
            rd_q_reg <= rd_s_reg[2];
         end
         if (wr_s_reg[1] == wr_s_reg[2]) begin
            wr_q_reg <= wr_s_reg[2];
         end
         if (cs_s_reg[1] == cs_s_reg[2]) begin
            cs_q_reg <= cs_s_reg[2];
         end
      end
   end

   // Data pins delayed to line up with the accepted strobe levels: a strobe
   // takes four edges from pin to wr_act, so the byte seen on the last active
   // edge is the one that stood on the pins while the strobes were low.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_s1_reg <= `RST_ZERO8;
         data_s2_reg <= `RST_ZERO8;
         data_s3_reg <= `RST_ZERO8;
         data_s4_reg <= `RST_ZERO8;
      end else begin
         data_s1_reg <= data_in; // [R19]
         data_s2_reg <= data_s1_reg;
         data_s3_reg <= data_s2_reg;
         data_s4_reg <= data_s3_reg;
      end
   end

   // Input latch follows the delayed bus while a write is accepted; the last
   // byte taken before the strobes are seen high is the captured byte.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_latch_reg <= `RST_ZERO8;
      end else if (wr_act) begin
         in_latch_reg <= data_s4_reg; // [R4] [R7] [R19]
      end
   end

   // Completion trackers: an accepted strobe arms; after its release, next phase two then phase four fires.
   // A new strobe before completion re-arms, so one completion marks one transfer.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_pend_reg <= 1'b0;
         wr_seen2_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         rd_seen2_reg <= 1'b0;
      end else begin
         if (wr_act) begin
            wr_pend_reg <= 1'b1;
            wr_seen2_reg <= 1'b0;
         end else if (wr_done) begin
            wr_pend_reg <= 1'b0;
            wr_seen2_reg <= 1'b0;
         end else if (wr_pend_reg & at_p2) begin
            wr_seen2_reg <= 1'b1; // [R8]
         end
         if (rd_act) begin
            rd_pend_reg <= 1'b1;
            rd_seen2_reg <= 1'b0;
         end else if (rd_done) begin
            rd_pend_reg <= 1'b0;
            rd_seen2_reg <= 1'b0;
         end else if (rd_pend_reg & at_p2) begin
            rd_seen2_reg <= 1'b1; // [R14]
         end
      end
   end

   // Register file writes and flag updates; hardware sets win over clears other than mode off, so a
   // completion that meets a firmware clear in the same cycle is never lost.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_latch_reg <= `RST_ZERO8;
         data_dir_reg <= `RST_DATA_DIR;
         ctrl_pin_reg <= `RST_CTRL_PIN;
         status_dir_reg <= `RST_STATUS_DIR;
         core_int_reg <= `RST_ZERO8;
         periph_flags_reg <= `RST_ZERO8;
         periph_en_reg <= `RST_ZERO8;
         analog_cfg_reg <= `RST_ANALOG;
      end else begin
         if (wr_acc & hit_data) begin
            out_latch_reg <= pwdata[7:0]; // [R5]
         end
         if (wr_acc & hit_dir) begin
            data_dir_reg <= pwdata[7:0];
         end
         if (wr_acc & hit_ctrl) begin
            ctrl_pin_reg <= pwdata[2:0];
         end
         if (wr_acc & hit_core) begin
            core_int_reg <= pwdata[7:0];
         end
         if (wr_acc & hit_en) begin
            periph_en_reg <= pwdata[7:0];
         end
         if (wr_acc & hit_ana) begin
            analog_cfg_reg <= pwdata[2:0];
         end
         // Mode and direction bits are firmware-written; flags are not.
         if (wr_acc & hit_stat) begin
            status_dir_reg[`BIT_MODE] <= pwdata[`BIT_MODE]; // [R1]
            status_dir_reg[2:0] <= pwdata[2:0];
         end
         // Overflow: firmware may only clear it; a new overflow wins.
         if (wr_done & status_dir_reg[`BIT_IBF]) begin
            status_dir_reg[`BIT_INPUT_OVERFLOW] <= 1'b1; // [R11]
         end else if (wr_acc & hit_stat & ~pwdata[`BIT_INPUT_OVERFLOW]) begin
            status_dir_reg[`BIT_INPUT_OVERFLOW] <= 1'b0; // [R17]
         end
         // Input full: set on write completion, cleared by a data read or by mode off.
         if (~mode) begin
            status_dir_reg[`BIT_IBF] <= 1'b0; // [R16]
         end else if (wr_done) begin
            status_dir_reg[`BIT_IBF] <= 1'b1; // [R8]
         end else if (rd_acc & hit_data) begin
            status_dir_reg[`BIT_IBF] <= 1'b0; // [R10]
         end
         // Output full: cleared at read start, set again by a firmware write.
         if (~mode | rd_raw | rd_act) begin
            status_dir_reg[`BIT_OBF] <= 1'b0; // [R13] [R15] [R16]
         end else if (wr_acc & hit_data) begin
            status_dir_reg[`BIT_OBF] <= 1'b1; // [R15]
         end
         // Irq flag: set by either completion, held until firmware clears it.
         if (wr_done | rd_done) begin
            periph_flags_reg[`BIT_SPIF] <= 1'b1; // [R9] [R14] [R18]
         end else if (wr_acc & hit_flags) begin
            periph_flags_reg[`BIT_SPIF] <= pwdata[`BIT_SPIF];
         end
         if (wr_acc & hit_flags) begin
            periph_flags_reg[6:0] <= pwdata[6:0];
         end
      end
   end

   // The output-full bit also reads clear combinationally the moment a read
   // strobe pair appears, so the clear needs no clock phase.
   wire [7:0] status_view = {status_dir_reg[7], status_dir_reg[6] & ~rd_raw, status_dir_reg[5:4], 1'b0,
                             status_dir_reg[2:0]}; // [R13]

   // APB answer: zero wait states, error on an unmapped address. Read data is
   // taken at the setup edge, so a read-to-clear flag changes only at access.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_any;
         prdata <= 32'h00000000;
         if (psel & ~penable & ~pwrite) begin
            if (hit_data) begin
               prdata <= {24'h000000, in_latch_reg}; // [R5]
            end else if (hit_ctrl) begin
               prdata <= {29'h0, mode ? {~cs_q_reg, ~wr_q_reg, ~rd_q_reg} : ctrl_pin_reg};
            end else if (hit_core) begin
               prdata <= {24'h000000, core_int_reg};
            end else if (hit_flags) begin
               prdata <= {24'h000000, periph_flags_reg};
            end else if (hit_stat) begin
               prdata <= {24'h000000, status_view};
            end else if (hit_en) begin
               prdata <= {24'h000000, periph_en_reg};
            end else if (hit_ana) begin
               prdata <= {29'h0, analog_cfg_reg};
            end else if (hit_dir) begin
               prdata <= {24'h000000, data_dir_reg};
            end
         end
      end
   end

   // Pin drive. In slave mode the strobes alone steer the data drivers and the
   // control pins are inputs; otherwise the direction registers rule. The raw
   // strobes steer the drivers so the bus turns one clock after a read starts.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_out <= 8'h00;
         data_oe <= 8'h00;
         ctrl_out <= 3'h0;
         ctrl_oe <= 3'h0;
         irq <= 1'b0;
      end else begin
         data_out <= out_latch_reg; // [R12]
         if (mode) begin
            data_oe <= (rd_raw & ~wr_raw) ? 8'hFF : 8'h00; // [R6] [R12]
            ctrl_oe <= 3'h0; // [R2]
         end else begin
            data_oe <= ~data_dir_reg;
            ctrl_oe <= ~status_dir_reg[2:0];
         end
         ctrl_out <= ctrl_pin_reg;
         irq <= periph_flags_reg[`BIT_SPIF] & periph_en_reg[`BIT_SPIF]; // [R18]
      end
   end

endmodule

/* File: dv/psp_checker.sv */
/* Assertions on the ports of the parallel slave port.
   Assumes a bind to the design and one pclk domain with async presetn. */
`timescale 1ns/1ps
module psp_checker (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // APB.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Pins and request.
   input wire rd_n_in,
   input wire wr_n_in,
   input wire cs_n_in,
   input wire [2:0] ctrl_oe,
   input wire [7:0] data_oe,
   input wire irq
);
   wire acc = psel && penable && pready && pwrite;
   // Firmware write that may lower irq: flags or enables.
   wire irq_wr = acc && (paddr == 32'h30 || paddr == 32'h230);
   wire wr_strobe = !cs_n_in && !wr_n_in;
   reg mode_q;
   reg en_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Snoop firmware writes, since mode and enable are not visible at the ports.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 1'b0;
         en_q <= 1'b0;
      end else if (acc) begin
         if (paddr == 32'h0000_0224) mode_q <= pwdata[4];
         if (paddr == 32'h0000_0230) en_q <= pwdata[7];
      end
   end
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held too long");
   err_zero_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad refused transfer");
   byte_wide_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   read_drive_a: assert property (mode_q && $past(mode_q) && !cs_n_in && !rd_n_in && wr_n_in |=> data_oe == 8'hFF)
      else $error("data pins not driven during read");
   pins_input_a: assert property (mode_q && $past(mode_q) |-> ctrl_oe == 3'h0)
      else $error("control pins driven in slave mode");
   irq_gated_a: assert property (!en_q && !$past(en_q) |-> !irq)
      else $error("irq while disabled");
   irq_held_a: assert property (irq && !irq_wr && !$past(irq_wr) |=> irq)
      else $error("irq dropped without firmware");
   wr_done_irq_a: assert property (mode_q && en_q && $past(wr_strobe) && !wr_strobe |-> ##[1:16] irq)
      else $error("no irq after external write");
   cover property (mode_q && !cs_n_in && !rd_n_in);
   cover property (pslverr);
   cover property ($rose(irq));
endmodule
bind parallel_slave_port psp_checker psp_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .rd_n_in, .wr_n_in, .cs_n_in, .ctrl_oe, .data_oe, .irq);

/* File: dv/ext_host.sv */
/* Model of the external byte-wide bus master on the slave port pins.
   Assumes its tasks are called just after a rising pclk edge. */
`timescale 1ns/1ps
module ext_host (
   // Clock.
   input wire pclk,
   // Strobes, active low.
   output reg rd_n,
   output reg wr_n,
   output reg cs_n,
   // Data bus.
   output reg [7:0] bus,
   input wire [7:0] data_out,
   input wire [7:0] data_oe
);
   // Strobes idle high; a released bus shows the inverse of its last byte.
   initial begin
      rd_n = 1'b1;
      wr_n = 1'b1;
      cs_n = 1'b1;
      bus = 8'h00;
   end
   // Data stays put while both strobes are low for n edges.
   task ext_write(input [7:0] d, input integer n);
      begin
         cs_n <= 1'b0;
         wr_n <= 1'b0;
         bus <= d;
         repeat (n) @(posedge pclk);
         cs_n <= 1'b1;
         wr_n <= 1'b1;
         bus <= ~d;
         @(posedge pclk);
      end
   endtask
   // The byte is taken at the last edge of the strobe window.
   task ext_read(input integer n, output [7:0] q);
      begin
         cs_n <= 1'b0;
         rd_n <= 1'b0;
         repeat (n) @(posedge pclk);
         q = data_out & data_oe;
         cs_n <= 1'b1;
         rd_n <= 1'b1;
         @(posedge pclk);
      end
   endtask
endmodule

/* File: dv/tb_top.sv */
/* Self-checking bench for the parallel slave port over APB and its pins.
   Assumes the design, its register header and the host model. */
`timescale 1ns/1ps
`include "slave_port_regs.vh"
module tb_top;
   localparam [31:0] A_DAT = 4 * `IDX_DATA_LATCH;
   localparam [31:0] A_CT = 4 * `IDX_CTRL_PIN;
   localparam [31:0] A_FLG = 4 * `IDX_PERIPH_FLAGS;
   localparam [31:0] A_ST = 4 * `IDX_STATUS_DIR;
   localparam [31:0] A_EN = 4 * `IDX_PERIPH_EN;
   localparam [31:0] A_AN = 4 * `IDX_ANALOG_CFG;
   localparam [31:0] A_DIR = 32'h220;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [31:0] paddr = 32'h0;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, rd_n, wr_n, cs_n, irq;
   wire [2:0] ctrl_out, ctrl_oe;
   wire [7:0] bus, data_out, data_oe;
   // The shared data wire follows whichever side enables its drivers.
   wire [7:0] data_in = (data_oe & data_out) | (~data_oe & bus);
   integer err_total = 0;
   integer checks_done = 0;
   integer cyc = 0;
   reg [31:0] q;
   reg e;
   reg [7:0] hb;
   always #25 pclk = ~pclk;
   parallel_slave_port parallel_slave_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rd_n_in(rd_n), .wr_n_in(wr_n), .cs_n_in(cs_n), .ctrl_out(ctrl_out), .ctrl_oe(ctrl_oe),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .irq(irq));
   ext_host ext_host_i (.pclk(pclk), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .bus(bus), .data_out(data_out),
      .data_oe(data_oe));
   task conclude;
      begin
         $display("Checks %0d, mismatches %0d", checks_done, err_total);
         if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // A hang ends here instead of running forever.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         conclude;
      end
   end
   // One transfer, then an idle cycle so psel is never driven twice at one edge.
   task apb(input w, input [31:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rdc(input [31:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(q, exp);
      end
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(A_DAT, 32'h0);
      rdc(A_FLG, 32'h0);
      rdc(A_ST, 32'h07);
      rdc(A_EN, 32'h0);
      rdc(A_AN, 32'h0);
      rdc(A_DIR, 32'hFF);
      apb(1'b0, 32'h100, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("Test reset done");
      apb(1'b1, A_AN, 32'h07);
      apb(1'b1, A_ST, 32'h17);
      apb(1'b1, A_DIR, 32'h0);
      apb(1'b1, A_DAT, 32'hA5);
      rdc(A_ST, 32'h57);
      fork
         ext_host_i.ext_read(20, hb);
         begin
            repeat (8) @(posedge pclk);
            rdc(A_ST, 32'h17);
         end
      join
      chk({24'h0, hb}, 32'hA5);
      repeat (16) @(posedge pclk);
      rdc(A_FLG, 32'h80);
      apb(1'b1, A_FLG, 32'h0);
      rdc(A_FLG, 32'h0);
      $display("Test external read done");
      ext_host_i.ext_write(8'h3C, 4);
      repeat (16) @(posedge pclk);
      rdc(A_ST, 32'h97);
      rdc(A_FLG, 32'h80);
      apb(1'b1, A_EN, 32'h80);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, A_FLG, 32'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      $display("Test external write done");
      ext_host_i.ext_write(8'h5A, 20);
      repeat (16) @(posedge pclk);
      rdc(A_ST, 32'hB7);
      chk({31'h0, irq}, 32'h1);
      rdc(A_DAT, 32'h5A);
      rdc(A_ST, 32'h37);
      $display("Test overflow done");
      apb(1'b1, A_ST, 32'h27);
      rdc(A_ST, 32'h27);
      chk({24'h0, data_oe}, 32'hFF);
      apb(1'b1, A_FLG, 32'h0);
      ext_host_i.ext_write(8'hC3, 4);
      repeat (16) @(posedge pclk);
      rdc(A_FLG, 32'h0);
      apb(1'b1, A_DAT, 32'h11);
      rdc(A_ST, 32'h27);
      apb(1'b1, A_ST, 32'h07);
      rdc(A_ST, 32'h07);
      apb(1'b1, A_CT, 32'h05);
      apb(1'b1, A_ST, 32'h00);
      rdc(A_CT, 32'h05);
      chk({26'h0, ctrl_oe, ctrl_out}, 32'h3D);
      $display("Test mode off done");
      conclude;
   end
endmodule
